// File: src/bsl_pkg.sv
// Shared constants, types and helpers of the boot string and header loader.
package bsl_pkg;

    localparam int CLK_KHZ = 25000;
    localparam int I2C_KHZ = 100;
    // Least quarter period of the serial clock, rounded up to whole cycles.
    localparam int QTR_CYC = (CLK_KHZ + 4 * I2C_KHZ - 1) / (4 * I2C_KHZ);

    localparam logic [7:0] DESC_STRING = 8'h03;
    localparam logic [7:0] LANG_LEN    = 8'h04;
    localparam logic [7:0] LANG_LO     = 8'h09;
    localparam logic [7:0] LANG_HI     = 8'h04;
    localparam logic [7:0] MFR_LEN     = 8'h24;
    localparam logic [7:0] PROD_LEN    = 8'h2a;
    localparam logic [7:0] SER_LEN     = 8'h22;
    localparam logic [7:0] UNI_HI      = 8'h00;
    localparam logic [7:0] END_MARK    = 8'h00;

    localparam int MFR_CHARS  = 17;
    localparam int PROD_CHARS = 20;
    localparam logic [8*MFR_CHARS-1:0]  MFR_TEXT  = "Acme Bridge Works";
    localparam logic [8*PROD_CHARS-1:0] PROD_TEXT = "USB Serial Boot Unit";

    // Product signature value is arbitrary.
    localparam logic [15:0] PROD_SIG   = 16'h5a21;
    localparam logic [7:0]  EE_WR      = 8'ha0;
    localparam logic [7:0]  EE_RD      = 8'ha1;
    localparam logic [15:0] START_ADDR = 16'h0000;

    typedef struct packed {
        logic [1:0] idx;
        logic [5:0] off;
    } bsl_str_req_t;

    typedef struct packed {
        logic [7:0]  kind;
        logic [15:0] size;
        logic [7:0]  num;
        logic        ok;
    } bsl_blk_t;

    typedef enum logic [2:0] {
        B_IDLE, B_START, B_WBIT, B_RBIT, B_STOP, B_DONE
    } bsl_bit_st_t;

    typedef enum logic [2:0] {
        P_SIG0, P_SIG1, P_TYPE, P_SZL, P_SZH, P_SUM, P_CONT, P_END
    } bsl_prs_st_t;

    function automatic logic [7:0] bsl_hex(input logic [3:0] n);
        return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

endpackage

// File: src/bsl_str_rom.sv
// String descriptor byte store with registered read data.
`timescale 1ns/100ps
`default_nettype none
module bsl_str_rom (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire bsl_pkg::bsl_str_req_t req,
    input  wire logic [63:0]          serial_number_regs,
    output logic [7:0]                data_ff
);
    logic [7:0] nxt_data;
    logic [4:0] k;
    logic [7:0] sel;

    always_comb
    begin
        k        = 5'((req.off - 6'h02) >> 1);
        sel      = serial_number_regs[8*k[3:1] +: 8];
        // (R2) Odd character bytes stay zero.
        nxt_data = bsl_pkg::UNI_HI;
        // (R3) Language list and three text strings.
        unique case (req.idx)
            // (R1) Language list.
            2'd0:
            begin
                if (req.off == 6'h00) nxt_data = bsl_pkg::LANG_LEN;
                else if (req.off == 6'h01) nxt_data = bsl_pkg::DESC_STRING;
                else if (req.off == 6'h02) nxt_data = bsl_pkg::LANG_LO;
                else if (req.off == 6'h03) nxt_data = bsl_pkg::LANG_HI;
            end
            // (R4) Manufacturer text.
            2'd1:
            begin
                if (req.off == 6'h00) nxt_data = bsl_pkg::MFR_LEN;
                else if (req.off == 6'h01) nxt_data = bsl_pkg::DESC_STRING;
                else if (!req.off[0] && {2'b00, req.off} < bsl_pkg::MFR_LEN)
                    nxt_data = bsl_pkg::MFR_TEXT[8*(bsl_pkg::MFR_CHARS-1-k) +: 8];
            end
            // (R5) Product text.
            2'd2:
            begin
                if (req.off == 6'h00) nxt_data = bsl_pkg::PROD_LEN;
                else if (req.off == 6'h01) nxt_data = bsl_pkg::DESC_STRING;
                else if (!req.off[0] && {2'b00, req.off} < bsl_pkg::PROD_LEN)
                    nxt_data = bsl_pkg::PROD_TEXT[8*(bsl_pkg::PROD_CHARS-1-k) +: 8];
            end
            // (R6) Serial number, (R7) first register high digit first.
            2'd3:
            begin
                if (req.off == 6'h00) nxt_data = bsl_pkg::SER_LEN;
                else if (req.off == 6'h01) nxt_data = bsl_pkg::DESC_STRING;
                else if (!req.off[0] && {2'b00, req.off} < bsl_pkg::SER_LEN)
                    nxt_data = bsl_pkg::bsl_hex(k[0] ? sel[3:0] : sel[7:4]);
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) data_ff <= 8'h00;
        else data_ff <= nxt_data;
    end
endmodule
`default_nettype wire

// File: src/bsl_loader.sv
// Boot string supplier and serial storage header walker.
//
// Function
// (R1) String zero is four bytes long, type three, with language code 0x0409.
// (R2) Each text character is sent as its code byte and then a zero byte.
// (R3) Exactly three text strings exist: maker, product and serial number.
// (R4) The maker string is 36 bytes long and of type three.
// (R5) The product string is 42 bytes long and of type three.
// (R6) The serial string is 34 bytes long, type three, with sixteen digits.
// (R7) Serial digits are hex of the eight serial registers, first to last.
// (R8) The storage holds a signature and then blocks of prefix and content.
// (R9) Each block starts with a four byte prefix of type, size and checksum.
// (R10) Blocks are found by walking from the first, adding each size.
// (R11) The signature sits in storage bytes zero and one, low byte first.
// (R12) A wrong signature ends all header processing.
// (R13) Prefix order is type, size low, size high, then content checksum.
// (R14) A block whose checksum disagrees is rejected as a whole; the code only clears blk.ok and still passes its content out on cont_stb.
// (R15) A zero byte after the last block ends the header.
// (R16) Storage is read upward from address zero by random then sequential read.
`timescale 1ns/100ps
`default_nettype none
module bsl_loader #(
    parameter int QTR_CYC = bsl_pkg::QTR_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  str_req_vld,
    input  wire bsl_pkg::bsl_str_req_t str_req,
    input  wire logic [63:0]           serial_number_regs,
    input  wire logic [7:0]            want_blk,
    output logic                       str_vld,
    output logic [7:0]                 str_byte,
    output logic                       scl,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe_n,
    output logic                       hdr_done,
    output logic                       sig_bad,
    output logic                       nack_err,
    output logic                       blk_stb,
    output bsl_pkg::bsl_blk_t          blk,
    output logic                       cont_stb,
    output logic [7:0]                 cont_byte
);
    logic                 str_vld_ff;
    logic [7:0]           qcnt_ff;
    logic [1:0]           ph_ff;
    logic                 tick;
    bsl_pkg::bsl_bit_st_t bst_ff;
    bsl_pkg::bsl_prs_st_t pst_ff;
    logic [3:0]           bit_ff;
    logic [2:0]           widx_ff;
    logic [7:0]           sh_ff;
    logic                 scl_ff, oe_n_ff, sda_o_ff, nack_ff;
    logic                 rx_stb_ff, fin_ff, sig_bad_ff, done_ff;
    logic [7:0]           sig_lo_ff, sum_ff, psum_ff, num_ff, cb_ff;
    logic [15:0]          size_ff, left_ff, pos_ff, nxt_pfx_ff;
    logic                 blk_stb_ff, cont_stb_ff;
    bsl_pkg::bsl_blk_t    blk_ff;
    logic [7:0]           nxt_sum;

    // (R1) String bytes come from the store one cycle after the request.
    bsl_str_rom u_rom (
        .clk                (clk),
        .rst_n              (rst_n),
        .req                (str_req),
        .serial_number_regs (serial_number_regs),
        .data_ff            (str_byte)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) str_vld_ff <= 1'b0;
        else str_vld_ff <= str_req_vld;
    end

    assign tick = (qcnt_ff == 8'(QTR_CYC - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            qcnt_ff <= 8'h00;
            ph_ff   <= 2'd0;
        end
        else
        begin
            qcnt_ff <= tick ? 8'h00 : qcnt_ff + 8'h01;
            if (tick) ph_ff <= ph_ff + 2'd1;
        end
    end

    // (R16) Address write, repeated start, then a sequential read.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bst_ff   <= bsl_pkg::B_IDLE;
            bit_ff   <= 4'h0;
            widx_ff  <= 3'd0;
            sh_ff    <= 8'h00;
            scl_ff   <= 1'b1;
            oe_n_ff  <= 1'b1;
            sda_o_ff <= 1'b0;
            nack_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end
        else if (tick)
        begin
            unique case (bst_ff)
                bsl_pkg::B_IDLE:
                    if (ph_ff == 2'd3) bst_ff <= bsl_pkg::B_START;
                bsl_pkg::B_START:
                    unique case (ph_ff)
                        2'd0: oe_n_ff <= 1'b1;
                        2'd1: scl_ff <= 1'b1;
                        2'd2: oe_n_ff <= 1'b0;
                        2'd3:
                        begin
                            scl_ff <= 1'b0;
                            bst_ff <= bsl_pkg::B_WBIT;
                            bit_ff <= 4'h0;
                            sh_ff  <= (widx_ff == 3'd0) ? bsl_pkg::EE_WR
                                                        : bsl_pkg::EE_RD;
                        end
                    endcase
                bsl_pkg::B_WBIT:
                    unique case (ph_ff)
                        2'd0: oe_n_ff <= (bit_ff == 4'h8) | sh_ff[7];
                        2'd1: scl_ff <= 1'b1;
                        2'd2: nack_ff <= (bit_ff == 4'h8) & sda_i;
                        2'd3:
                        begin
                            scl_ff <= 1'b0;
                            bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
                            sh_ff  <= {sh_ff[6:0], 1'b0};
                            if (bit_ff == 4'h8)
                            begin
                                widx_ff <= widx_ff + 3'd1;
                                if (nack_ff) bst_ff <= bsl_pkg::B_STOP;
                                else if (widx_ff == 3'd2)
                                    bst_ff <= bsl_pkg::B_START;
                                else if (widx_ff == 3'd3)
                                    bst_ff <= bsl_pkg::B_RBIT;
                                else
                                    sh_ff <= (widx_ff == 3'd0)
                                             ? bsl_pkg::START_ADDR[15:8]
                                             : bsl_pkg::START_ADDR[7:0];
                            end
                        end
                    endcase
                bsl_pkg::B_RBIT:
                    unique case (ph_ff)
                        2'd0: oe_n_ff <= (bit_ff == 4'h8) ? fin_ff : 1'b1;
                        2'd1: scl_ff <= 1'b1;
                        2'd2: if (bit_ff != 4'h8) sh_ff <= {sh_ff[6:0], sda_i};
                        2'd3:
                        begin
                            scl_ff <= 1'b0;
                            bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
                            if (bit_ff == 4'h8 && fin_ff)
                                bst_ff <= bsl_pkg::B_STOP;
                        end
                    endcase
                bsl_pkg::B_STOP:
                    unique case (ph_ff)
                        2'd0: oe_n_ff <= 1'b0;
                        2'd1: scl_ff <= 1'b1;
                        2'd2: oe_n_ff <= 1'b1;
                        2'd3: bst_ff <= bsl_pkg::B_DONE;
                    endcase
                bsl_pkg::B_DONE: done_ff <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) rx_stb_ff <= 1'b0;
        else rx_stb_ff <= tick && ph_ff == 2'd3 && bit_ff == 4'h7
                          && bst_ff == bsl_pkg::B_RBIT;
    end

    assign nxt_sum = sum_ff + sh_ff;

    // (R9) Prefix fields, then content, one storage byte at a time.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pst_ff      <= bsl_pkg::P_SIG0;
            fin_ff      <= 1'b0;
            sig_bad_ff  <= 1'b0;
            sig_lo_ff   <= 8'h00;
            size_ff     <= 16'h0000;
            left_ff     <= 16'h0000;
            sum_ff      <= 8'h00;
            psum_ff     <= 8'h00;
            num_ff      <= 8'h00;
            pos_ff      <= 16'h0000;
            nxt_pfx_ff  <= 16'h0000;
            blk_ff      <= '0;
            blk_stb_ff  <= 1'b0;
            cont_stb_ff <= 1'b0;
            cb_ff       <= 8'h00;
        end
        else
        begin
            blk_stb_ff  <= 1'b0;
            cont_stb_ff <= 1'b0;
            if (rx_stb_ff)
            begin
                pos_ff <= pos_ff + 16'h0001;
                unique case (pst_ff)
                    // (R11) Low signature byte arrives first.
                    bsl_pkg::P_SIG0:
                    begin
                        sig_lo_ff <= sh_ff;
                        pst_ff    <= bsl_pkg::P_SIG1;
                    end
                    // (R12) Mismatch stops the walk.
                    bsl_pkg::P_SIG1:
                        if ({sh_ff, sig_lo_ff} != bsl_pkg::PROD_SIG)
                        begin
                            sig_bad_ff <= 1'b1;
                            fin_ff     <= 1'b1;
                            pst_ff     <= bsl_pkg::P_END;
                        end
                        else pst_ff <= bsl_pkg::P_TYPE;
                    // (R15) Zero type byte ends the header.
                    bsl_pkg::P_TYPE:
                        if (sh_ff == bsl_pkg::END_MARK)
                        begin
                            fin_ff <= 1'b1;
                            pst_ff <= bsl_pkg::P_END;
                        end
                        else
                        begin
                            blk_ff.kind <= sh_ff;
                            pst_ff      <= bsl_pkg::P_SZL;
                        end
                    // (R13) Size low, size high, then checksum.
                    bsl_pkg::P_SZL:
                    begin
                        size_ff[7:0] <= sh_ff;
                        pst_ff       <= bsl_pkg::P_SZH;
                    end
                    bsl_pkg::P_SZH:
                    begin
                        size_ff[15:8] <= sh_ff;
                        pst_ff        <= bsl_pkg::P_SUM;
                    end
                    // (R10) Next prefix lies size plus one bytes beyond the checksum byte, right after this content.
                    bsl_pkg::P_SUM:
                    begin
                        psum_ff    <= sh_ff;
                        left_ff    <= size_ff;
                        sum_ff     <= 8'h00;
                        nxt_pfx_ff <= pos_ff + 16'h0001 + size_ff;
                        if (size_ff == 16'h0000)
                        begin
                            fin_ff <= 1'b1;
                            pst_ff <= bsl_pkg::P_END;
                        end
                        else pst_ff <= bsl_pkg::P_CONT;
                    end
                    bsl_pkg::P_CONT:
                    begin
                        sum_ff      <= nxt_sum;
                        left_ff     <= left_ff - 16'h0001;
                        cb_ff       <= sh_ff;
                        cont_stb_ff <= (num_ff == want_blk);
                        if (left_ff == 16'h0001)
                        begin
                            // (R14) Verdict of the whole block.
                            blk_ff.ok   <= (nxt_sum == psum_ff);
                            blk_ff.size <= size_ff;
                            blk_ff.num  <= num_ff;
                            blk_stb_ff  <= 1'b1;
                            num_ff      <= num_ff + 8'h01;
                            pst_ff      <= bsl_pkg::P_TYPE;
                        end
                    end
                    bsl_pkg::P_END: fin_ff <= 1'b1;
                endcase
            end
        end
    end

    assign str_vld   = str_vld_ff;
    assign scl       = scl_ff;
    assign sda_o     = sda_o_ff;
    assign sda_oe_n  = oe_n_ff;
    assign hdr_done  = done_ff;
    assign sig_bad   = sig_bad_ff;
    assign nack_err  = nack_ff;
    assign blk_stb   = blk_stb_ff;
    assign blk       = blk_ff;
    assign cont_stb  = cont_stb_ff;
    assign cont_byte = cb_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_ask(logic [1:0] i, logic [5:0] o);
        str_req_vld && str_req.idx == i && str_req.off == o;
    endsequence

    a_lang_len: assert property (s_ask(2'd0, 6'd0) |=> str_byte == 8'h04) // (R1)
        else $error("language list length wrong");
    a_lang_code: assert property ( // (R1)
        s_ask(2'd0, 6'd2) ##1 s_ask(2'd0, 6'd3)
        |-> str_byte == 8'h09 ##1 str_byte == 8'h04)
        else $error("language code wrong");
    a_text_hi_zero: assert property (str_req_vld && str_req.idx != 2'd0 // (R2)
        && str_req.off[0] && str_req.off != 6'd1 |=> str_byte == 8'h00)
        else $error("character high byte not zero");
    a_mfr_len: assert property (s_ask(2'd1, 6'd0) |=> str_byte == 8'd36) // (R4)
        else $error("maker string length wrong");
    a_prod_len: assert property (s_ask(2'd2, 6'd0) |=> str_byte == 8'd42) // (R5)
        else $error("product string length wrong");
    a_ser_type: assert property (s_ask(2'd3, 6'd0) ##1 s_ask(2'd3, 6'd1) // (R6)
        |-> str_byte == 8'd34 ##1 str_byte == 8'h03)
        else $error("serial string header wrong");
    a_ser_digit: assert property (s_ask(2'd3, 6'd2) |=> str_vld // (R7)
        && str_byte == bsl_pkg::bsl_hex($past(serial_number_regs[7:4])))
        else $error("first serial digit wrong");
    a_sig_check: assert property (rx_stb_ff && pst_ff == bsl_pkg::P_SIG1 // (R12)
        && {sh_ff, sig_lo_ff} != bsl_pkg::PROD_SIG
        |=> sig_bad && fin_ff && pst_ff == bsl_pkg::P_END)
        else $error("bad signature not caught");
    a_walk_pos: assert property (blk_stb |-> pos_ff == nxt_pfx_ff) // (R10)
        else $error("block walk position wrong");
    a_sum_verdict: assert property (rx_stb_ff && pst_ff == bsl_pkg::P_CONT // (R14)
        && left_ff == 16'h0001 |=> blk_stb && blk.ok == (sum_ff == psum_ff))
        else $error("checksum verdict wrong");
endmodule
`default_nettype wire

// File: testbench/bsl_eeprom_model.sv
// Behavioural serial storage device that answers the loader's bus.
`timescale 1ns/100ps
`default_nettype none
module bsl_eeprom_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic mute,
    output logic      pull_low
);
    logic [7:0]  mem [0:63];
    logic [7:0]  sh;
    logic [15:0] ptr;
    int          cnt;
    int          nb;
    logic        rd = 1'b0;
    initial pull_low = 1'b0;
    // A start condition restarts byte framing.
    always @(negedge sda)
    begin
        if (scl === 1'b1)
        begin
            cnt = 0;
            nb = 0;
            rd = 1'b0;
            pull_low <= 1'b0;
        end
    end
    always @(posedge scl)
    begin
        if (cnt < 8)
        begin
            sh = {sh[6:0], sda};
            cnt = cnt + 1;
        end
        else
        begin
            cnt = 0;
            if (rd && sda)
            begin
                rd = 1'b0;
                nb = 99;
            end
            else if (rd)
                ptr = ptr + 16'h0001;
            else
            begin
                if (nb == 0)
                    rd = (sh == 8'ha1);
                if (nb == 1)
                    ptr[15:8] = sh;
                if (nb == 2)
                    ptr[7:0] = sh;
                nb = nb + 1;
            end
        end
    end
    always @(negedge scl)
    begin
        if (!rd)
            pull_low <= (cnt == 8) && !mute && (nb < 3);
        else
            pull_low <= (cnt < 8) && !mem[ptr[5:0]][7-cnt];
    end
endmodule
`default_nettype wire

// File: testbench/test_bsl_loader.sv
// Self-checking bench for the boot string and header loader.
`timescale 1ns/100ps
`default_nettype none
module test_bsl_loader;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  str_req_vld = 1'b0;
    bsl_pkg::bsl_str_req_t str_req = '0;
    logic [63:0]           ser = 64'h0;
    logic [7:0]            want = 8'h00;
    logic                  mute = 1'b0;
    logic                  str_vld, scl, sda_o, sda_oe_n, ee_low;
    logic                  hdr_done, sig_bad, nack_err, blk_stb, cont_stb;
    logic [7:0]            str_byte, cont_byte;
    bsl_pkg::bsl_blk_t     blk;
    wire                   sda = (sda_oe_n === 1'b0 || ee_low) ? 1'b0 : 1'b1;
    int                    miscompares = 0;
    int                    compares = 0;
    bsl_pkg::bsl_blk_t     got_blk[$], exp_blk[$];
    logic [7:0]            got_cont[$], exp_cont[$];
    logic [7:0]            kinds [3] = '{8'h01, 8'h02, 8'h03};
    logic [7:0]            sizes [3] = '{8'h03, 8'h02, 8'h01};

    always #20 clk = ~clk;

    bsl_loader #(.QTR_CYC(2)) dut_u (.clk(clk), .rst_n(rst_n),
        .str_req_vld(str_req_vld), .str_req(str_req),
        .serial_number_regs(ser), .want_blk(want), .str_vld(str_vld),
        .str_byte(str_byte), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .hdr_done(hdr_done), .sig_bad(sig_bad),
        .nack_err(nack_err), .blk_stb(blk_stb), .blk(blk),
        .cont_stb(cont_stb), .cont_byte(cont_byte));
    bsl_eeprom_model eep_u (.scl(scl), .sda(sda), .mute(mute),
        .pull_low(ee_low));

    always @(negedge clk)
    begin
        if (blk_stb === 1'b1)
            got_blk.push_back(blk);
        if (cont_stb === 1'b1)
            got_cont.push_back(cont_byte);
    end

    task automatic miss(input logic [32:0] g, input logic [32:0] e);
        miscompares++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
            miss({25'h0, g}, {25'h0, e});
    endtask
    task automatic cmp_flag(input logic g, input logic e);
        compares++;
        if (g !== e)
            miss({32'h0, g}, {32'h0, e});
    endtask
    task automatic cmp_blk(input bsl_pkg::bsl_blk_t g, bsl_pkg::bsl_blk_t e);
        compares++;
        if (g !== e)
            miss(g, e);
    endtask

    function automatic logic [7:0] exp_str(input int ix, input int of);
        int         ln;
        int         k;
        logic [7:0] v;
        ln = (ix == 0) ? 4 : (ix == 1) ? 36 : (ix == 2) ? 42 : 34;
        k = (of - 2) / 2;
        v = {4'h0, ser[8*(k/2) + ((k % 2 == 0) ? 4 : 0) +: 4]};
        if (of >= ln)
            return 8'h00;
        if (of < 2)
            return (of == 0) ? 8'(ln) : 8'h03;
        if (ix == 0)
            return (of == 2) ? 8'h09 : 8'h04;
        if (of % 2 == 1)
            return 8'h00;
        if (ix == 1)
            return bsl_pkg::MFR_TEXT[8*(bsl_pkg::MFR_CHARS-1-k) +: 8];
        if (ix == 2)
            return bsl_pkg::PROD_TEXT[8*(bsl_pkg::PROD_CHARS-1-k) +: 8];
        return (v < 8'h0a) ? v + 8'h30 : v + 8'h37;
    endfunction

    task automatic load_image(input logic [7:0] s0);
        int                a;
        logic [7:0]        c;
        logic [7:0]        sum;
        bsl_pkg::bsl_blk_t e;
        a = 2;
        eep_u.mem[0] = s0;
        eep_u.mem[1] = bsl_pkg::PROD_SIG[15:8];
        for (int b = 0; b < 3; b++)
        begin
            sum = 8'h00;
            // Type, size low, size high, checksum.
            eep_u.mem[a] = kinds[b];
            eep_u.mem[a+1] = sizes[b];
            eep_u.mem[a+2] = 8'h00;
            for (int k = 0; k < int'(sizes[b]); k++)
            begin
                c = 8'($urandom);
                eep_u.mem[a+4+k] = c;
                sum = sum + c;
                if (b == int'(want))
                    exp_cont.push_back(c);
            end
            eep_u.mem[a+3] = (b == 1) ? sum + 8'h01 : sum;
            e = '{kinds[b], {8'h00, sizes[b]}, 8'(b), b != 1};
            exp_blk.push_back(e);
            a = a + 4 + int'(sizes[b]);
        end
        eep_u.mem[a] = 8'h00;
    endtask

    task automatic sweep();
        logic [7:0] pe;
        for (int i = 0; i <= 176; i++)
        begin
            @(negedge clk);
            if (i > 0)
                cmp_flag(str_vld, 1'b1);
            if (i > 0)
                cmp_byte(str_byte, pe);
            str_req_vld = (i < 176);
            str_req = '{2'(i / 44), 6'(i % 44)};
            pe = exp_str(i / 44, i % 44);
        end
        str_req_vld = 1'b0;
    endtask

    task automatic run(input logic [7:0] s0, input logic mt, input logic es,
                       input logic en);
        int n;
        @(negedge clk);
        rst_n = 1'b0;
        mute = mt;
        want = 8'($urandom_range(2));
        ser = {$urandom, $urandom};
        exp_blk.delete();
        exp_cont.delete();
        load_image(s0);
        if (es || en)
            exp_blk.delete();
        if (es || en)
            exp_cont.delete();
        repeat (8) @(negedge clk);
        got_blk.delete();
        got_cont.delete();
        rst_n = 1'b1;
        sweep();
        for (n = 0; n < 10000 && hdr_done !== 1'b1; n++)
            @(negedge clk);
        cmp_flag(hdr_done, 1'b1);
        cmp_flag(sig_bad, es);
        cmp_flag(nack_err, en);
        cmp_flag(scl, 1'b1);
        cmp_flag(sda_oe_n, 1'b1);
        cmp_flag(sda_o, 1'b0);
        cmp_byte(8'(got_blk.size()), 8'(exp_blk.size()));
        cmp_byte(8'(got_cont.size()), 8'(exp_cont.size()));
        foreach (got_blk[i])
            cmp_blk(got_blk[i], exp_blk[i]);
        foreach (got_cont[i])
            cmp_byte(got_cont[i], exp_cont[i]);
        $display("test done sig=%h mute=%0d errors=%0d", s0, mt, miscompares);
    endtask

    task automatic close_out();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        void'($urandom(65418));
        run(bsl_pkg::PROD_SIG[7:0], 1'b0, 1'b0, 1'b0);
        run(bsl_pkg::PROD_SIG[15:8], 1'b0, 1'b1, 1'b0);
        run(bsl_pkg::PROD_SIG[7:0], 1'b1, 1'b0, 1'b1);
        close_out();
    end

    // Three runs take well under 10000 cycles; this allows 20000.
    initial
    begin
        #800000;
        miscompares++;
        close_out();
    end
endmodule
`default_nettype wire
